/* File: design/bus_trace_recorder.sv */
// bus trace recorder: capture fifo and circular trace memory
// Function
// - newest record is 0, older ones negative
// - with delay, stop cycle is 0, later positive
// - record holds address and data bus
// - record holds 8/16-bit bus width flag
// - record holds active-low odd byte enable
// - record holds bus unit status code
// - record holds read, write or none
// - record holds active-low cycle valid strobe
// - record holds core-to-bus-unit status, none code
// - capture every cycle while program runs and the fifo has room, until the stop delay ends, 4M
// - full memory overwrites oldest records first

`timescale 1ns/1ns
`default_nettype none

module trace_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  // depth need not be a power of two, so the pointers wrap by compare
  function automatic logic [PW-1:0] next_slot(input logic [PW-1:0] ptr);
    logic [PW-1:0] nxt;
    if (ptr == PW'(DEPTH - 1)) begin
      nxt = '0;
    end else begin
      nxt = ptr + 1'b1;
    end
    return nxt;
  endfunction : next_slot

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_reg;
  logic [PW-1:0]    wr_next;
  logic [PW-1:0]    rd_reg;
  logic [PW-1:0]    rd_next;
  logic [PW:0]      cnt_reg;
  logic [PW:0]      cnt_next;
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_reg];

  // pointers and fill level move together, so full and empty never disagree
  assign wr_next  = push ? next_slot(wr_reg) : wr_reg;
  assign rd_next  = pop ? next_slot(rd_reg) : rd_reg;
  assign cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : trace_fifo

module bus_trace_recorder
  import trace_pkg::*;
#(
  parameter int MEM_DEPTH  = `TRC_MEM_DEPTH,
  parameter int FIFO_DEPTH = `TRC_FIFO_DEPTH
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rstn_i,
  input  wire logic                      run_i,
  input  wire trace_rec_t                bus_i,
  input  wire logic                      stop_cond_i,
  input  wire logic [`TRC_DELAY_W-1:0]   delay_count_i,
  input  wire logic                      rd_req_i,
  input  wire logic signed [$clog2(MEM_DEPTH):0] rd_rel_i,
  output trace_rec_t                     rd_data_o,
  output logic                           rd_valid_o,
  output logic [$clog2(MEM_DEPTH)-1:0]   wr_ptr_o,
  output logic [$clog2(MEM_DEPTH)-1:0]   stop_ptr_o,
  output logic                           stop_valid_o,
  output logic                           wrapped_o,
  output logic                           tracing_o,
  output logic                           dropped_o
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int RW = $bits(trace_rec_t);

  // memory depth must be a power of two so the pointer wraps by itself
  function automatic logic [AW-1:0] rel_index(input logic [AW-1:0] base,
                                              input logic signed [AW:0] rel);
    logic [AW:0] sum;
    sum = {1'b0, base} + rel;
    return sum[AW-1:0];
  endfunction : rel_index

  // acquisition control
  acq_state_t        state_reg, state_next;
  logic [AW-1:0]     seq_reg;
  logic [AW-1:0]     wr_ptr_reg;
  logic [AW-1:0]     stop_ptr_reg;
  logic              stop_valid_reg;
  logic              wrapped_reg;
  logic              dropped_reg;
  logic [`TRC_DELAY_W-1:0] delay_cnt_reg;

  // read side
  logic              rd_valid_reg;
  trace_rec_t        rd_data_reg;
  // one slot per captured cycle; a full-size build wants a real memory here
  trace_rec_t        mem_reg [MEM_DEPTH];


  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [RW-1:0]     fifo_out_data;

  // every cycle of the observed bus is offered while acquiring
  wire capturing = (state_reg == ACQ_RUN) || (state_reg == ACQ_DELAY);
  wire push      = capturing && fifo_in_ready;
  wire lost      = capturing && !fifo_in_ready;
  wire delay_set = (delay_count_i != '0);
  wire stop_hit  = (state_reg == ACQ_RUN) && push && stop_cond_i && delay_set;
  wire delay_end = (state_reg == ACQ_DELAY) && push
                   && (delay_cnt_reg == delay_count_i);
  // debugger reads take the memory port, so the drain stalls meanwhile
  wire drain     = fifo_out_valid && !rd_req_i;
  wire [AW-1:0] newest  = wr_ptr_reg - 1'b1;
  wire [AW-1:0] rd_base = stop_valid_reg ? stop_ptr_reg : newest;
  wire [AW-1:0] rd_idx  = rel_index(rd_base, rd_rel_i);

  // next values of the counters kept apart so the clocked blocks stay short
  wire [AW-1:0]           seq_next       = seq_reg + 1'b1;
  wire [AW-1:0]           wr_ptr_next    = wr_ptr_reg + 1'b1;
  wire [`TRC_DELAY_W-1:0] delay_cnt_next = delay_cnt_reg + 1'b1;

  trace_fifo #(
    .WIDTH (RW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (capturing),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (bus_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (drain),
    .out_data_o  (fifo_out_data)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ACQ_IDLE: begin
        if (run_i) begin
          state_next = ACQ_RUN;
        end
      end
      ACQ_RUN: begin
        if (!run_i) begin
          state_next = ACQ_IDLE;
        end else if (stop_hit) begin
          state_next = ACQ_DELAY;
        end
      end
      ACQ_DELAY: begin
        if (!run_i) begin
          state_next = ACQ_IDLE;
        end else if (delay_end) begin
          state_next = ACQ_HALT;
        end
      end
      // nothing more is captured until the program stops
      ACQ_HALT: begin
        if (!run_i) begin
          state_next = ACQ_IDLE;
        end
      end
      default: begin
        state_next = ACQ_IDLE;
      end
    endcase
  end

  // records land in capture order; oldest slot is overwritten on wrap
  always_ff @(posedge ref_clk_i) begin
    if (drain) begin
      mem_reg[wr_ptr_reg] <= trace_rec_t'(fifo_out_data);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state_reg <= ACQ_IDLE;
      seq_reg   <= AW'(`TRC_RST_PTR);
    end else begin
      state_reg <= state_next;
      if (push) begin
        seq_reg <= seq_next;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wr_ptr_reg  <= AW'(`TRC_RST_PTR);
      wrapped_reg <= 1'b0;
    end else if (drain) begin
      wr_ptr_reg <= wr_ptr_next;
      // sticky: tells the debugger that old slots now hold older records
      if (wr_ptr_reg == AW'(MEM_DEPTH - 1)) begin
        wrapped_reg <= 1'b1;
      end
    end
  end

  // stop slot equals the capture sequence number of the stop cycle
  // lost samples take no sequence number, so the two never drift apart
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      stop_ptr_reg   <= '0;
      stop_valid_reg <= 1'b0;
      delay_cnt_reg  <= '0;
    end else if (state_reg == ACQ_IDLE && run_i) begin
      stop_valid_reg <= 1'b0;
      delay_cnt_reg  <= '0;
    end else if (stop_hit) begin
      stop_ptr_reg   <= seq_reg;
      stop_valid_reg <= 1'b1;
      delay_cnt_reg  <= `TRC_DELAY_W'(1);
    end else if (state_reg == ACQ_DELAY && push) begin
      delay_cnt_reg <= delay_cnt_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dropped_reg <= 1'b0;
    end else if (state_reg == ACQ_IDLE && run_i) begin
      dropped_reg <= 1'b0;
    // a lost sample leaves a gap in the trace; the flag warns the debugger
    end else if (lost) begin
      dropped_reg <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end else begin
      rd_valid_reg <= rd_req_i;
      if (rd_req_i) begin
        rd_data_reg <= mem_reg[rd_idx];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      tracing_o  <= 1'b0;
      wr_ptr_o   <= '0;
      stop_ptr_o <= '0;
      stop_valid_o <= 1'b0;
      wrapped_o  <= 1'b0;
      dropped_o  <= 1'b0;
    end else begin
      tracing_o    <= capturing;
      wr_ptr_o     <= wr_ptr_reg;
      stop_ptr_o   <= stop_ptr_reg;
      stop_valid_o <= stop_valid_reg;
      wrapped_o    <= wrapped_reg;
      dropped_o    <= dropped_reg;
    end
  end

  // status outputs lag one cycle; read after the fifo has drained
  assign rd_valid_o = rd_valid_reg;
  assign rd_data_o  = rd_data_reg;
endmodule : bus_trace_recorder

`default_nettype wire

/* File: design/trace_regs.svh */
// widths, depths and reset values of the bus trace recorder
`ifndef TRACE_REGS_SVH
`define TRACE_REGS_SVH
`define TRC_ADDR_W     24
`define TRC_DATA_W     16
`define TRC_FIFO_DEPTH 16
`define TRC_MEM_DEPTH  4194304
`define TRC_DELAY_W    16
`define TRC_RST_PTR    0
`endif

/* File: design/trace_pkg.sv */
// types of the bus trace recorder
`include "trace_regs.svh"
package trace_pkg;
  typedef enum logic [2:0] {
    BUS_UNIT_NONE, BUS_UNIT_OTHER_MASTER, BUS_UNIT_INT_ACK,
    BUS_UNIT_FETCH_BYTE, BUS_UNIT_DATA_BYTE, BUS_UNIT_FETCH_WORD, BUS_UNIT_DATA_WORD
  } bus_unit_status_t;
  typedef enum logic [1:0] {DIR_NONE, DIR_READ, DIR_WRITE} dir_t;
  typedef enum logic {WIDTH_8B, WIDTH_16B} bus_width_t;
  typedef struct packed {
    logic [`TRC_ADDR_W-1:0] addr;
    logic [`TRC_DATA_W-1:0] data;
    bus_width_t             width;
    logic                   odd_byte_enable_n;
    bus_unit_status_t       bus_unit_status;
    dir_t                   dir;
    logic                   cycle_valid_n;
    logic [2:0]             cpu_status;
  } trace_rec_t;
  typedef enum {ACQ_IDLE, ACQ_RUN, ACQ_DELAY, ACQ_HALT} acq_state_t;
endpackage : trace_pkg

/* File: dv/trace_bus_model.sv */
// observed bus model: one distinct sample per cycle while the program runs
`timescale 1ns/1ns
`default_nettype none
package trace_tb_pkg;
  import trace_pkg::*;
  // every field but width derived from a running count, so all other codes come round
  function automatic trace_rec_t bus_sample(input logic [23:0] a);
    trace_rec_t r;
    r.addr = a;
    r.data = ~a[15:0];
    r.width = WIDTH_16B;
    r.odd_byte_enable_n = ~a[0];
    r.bus_unit_status = bus_unit_status_t'(3'(a % 24'h7));
    r.dir = dir_t'(2'(a % 24'h3));
    r.cycle_valid_n = a[1];
    r.cpu_status = a[4:2];
    return r;
  endfunction : bus_sample
endpackage : trace_tb_pkg

module trace_bus_model
  import trace_pkg::*;
  import trace_tb_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  output trace_rec_t bus_o
);
  logic [23:0] cnt_reg;
  // bus holds its last cycle while the program is stopped
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i)
      cnt_reg <= 24'h000000;
    else if (run_i)
      cnt_reg <= cnt_reg + 24'h000001;
  end
  assign bus_o = bus_sample(cnt_reg);
endmodule : trace_bus_model
`default_nettype wire

/* File: dv/bus_trace_recorder_checker.sv */
// port assertions for the bus trace recorder
`timescale 1ns/1ns
`default_nettype none
module bus_trace_recorder_checker #(
  parameter int MEM_DEPTH = 64
) (
  input wire logic                         ref_clk_i,
  input wire logic                         rstn_i,
  input wire logic                         run_i,
  input wire logic                         rd_req_i,
  input wire logic                         rd_valid_o,
  input wire logic [$clog2(MEM_DEPTH)-1:0] wr_ptr_o,
  input wire logic [$clog2(MEM_DEPTH)-1:0] stop_ptr_o,
  input wire logic                         stop_valid_o,
  input wire logic                         wrapped_o,
  input wire logic                         tracing_o
);
  localparam int AW = $clog2(MEM_DEPTH);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_rd_answer; rd_req_i |=> rd_valid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_quiet; !rd_req_i |=> !rd_valid_o; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read valid");
  property p_ptr_step; $changed(wr_ptr_o) |-> wr_ptr_o == AW'($past(wr_ptr_o) + 1); endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer skipped");
  property p_wrap_sticky; wrapped_o |=> wrapped_o; endproperty
  a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap flag lost");
  property p_wrap_set;
    $past(wr_ptr_o) == AW'(MEM_DEPTH - 1) && wr_ptr_o == '0 |-> ##[0:2] wrapped_o;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap not flagged");
  property p_run_start; $rose(run_i) |-> ##[1:3] tracing_o; endproperty
  a_run_start: assert property (p_run_start) else $error("capture not started");
  property p_run_end; !run_i [*3] |-> !tracing_o; endproperty
  a_run_end: assert property (p_run_end) else $error("capture after stop");
  property p_stop_hold; stop_valid_o && $past(stop_valid_o) |-> $stable(stop_ptr_o); endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop slot moved");
endmodule : bus_trace_recorder_checker
bind bus_trace_recorder bus_trace_recorder_checker #(.MEM_DEPTH(MEM_DEPTH)) chk_inst (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .run_i(run_i), .rd_req_i(rd_req_i),
  .rd_valid_o(rd_valid_o), .wr_ptr_o(wr_ptr_o), .stop_ptr_o(stop_ptr_o),
  .stop_valid_o(stop_valid_o), .wrapped_o(wrapped_o), .tracing_o(tracing_o));
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the bus trace recorder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import trace_pkg::*;
  import trace_tb_pkg::*;
  logic ref_clk_i = 0, rstn_i = 0, run_i = 0, stop_cond_i = 0, rd_req_i = 0;
  logic [15:0] delay_count_i = '0;
  logic signed [6:0] rd_rel_i = '0;
  trace_rec_t bus, rd_data;
  logic rd_valid, stop_valid, wrapped, tracing, dropped;
  logic [5:0] wr_ptr, stop_ptr;
  logic [23:0] base;
  int num_errors = 0, tests_run = 0;
  trace_bus_model trace_bus_model_inst (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .run_i(run_i), .bus_o(bus));
  bus_trace_recorder #(.MEM_DEPTH(64), .FIFO_DEPTH(16)) bus_trace_recorder_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .run_i(run_i), .bus_i(bus),
    .stop_cond_i(stop_cond_i), .delay_count_i(delay_count_i), .rd_req_i(rd_req_i),
    .rd_rel_i(rd_rel_i), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wr_ptr_o(wr_ptr),
    .stop_ptr_o(stop_ptr), .stop_valid_o(stop_valid), .wrapped_o(wrapped),
    .tracing_o(tracing), .dropped_o(dropped));
  initial forever #10 ref_clk_i = ~ref_clk_i;
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc
  task cmp(input string n, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask : cmp
  task rd(input int rel, input logic [23:0] a);
    @(posedge ref_clk_i);
    rd_req_i <= 1'b1;
    rd_rel_i <= 7'(rel);
    @(posedge ref_clk_i);
    rd_req_i <= 1'b0;
    #1;
    cmp("rd_valid_o", 64'(rd_valid), 64'h1);
    cmp("rd_data_o", 64'(rd_data), 64'(bus_sample(a)));
  endtask : rd
  task end_sim;
    $display("mismatches %0d comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    #20000;
    num_errors++;
    end_sim;
  end
  initial begin
    cyc(3);
    rstn_i <= 1'b1;
    cyc(2);
    run_i <= 1'b1;
    cyc(100);
    run_i <= 1'b0;
    cyc(24);
    // newest capture is the sample the bus still holds
    base = bus.addr;
    cmp("wrapped_o", 64'(wrapped), 64'h1);
    cmp("dropped_o", 64'(dropped), 64'h0);
    cmp("wr_ptr_o", 64'(wr_ptr), 64'(6'(base)));
    rd(0, base);
    rd(-1, base - 24'd1);
    rd(-63, base - 24'd63);
    delay_count_i <= 16'h0004;
    run_i <= 1'b1;
    base = bus.addr + 24'd10;
    do @(posedge ref_clk_i); while (bus.addr !== base - 24'd1);
    stop_cond_i <= 1'b1;
    cyc(1);
    stop_cond_i <= 1'b0;
    cyc(12);
    #1;
    cmp("tracing_o", 64'(tracing), 64'h0);
    cmp("stop_valid_o", 64'(stop_valid), 64'h1);
    cmp("stop_ptr_o", 64'(stop_ptr), 64'(6'(base - 24'd1)));
    cyc(1);
    run_i <= 1'b0;
    cyc(20);
    for (int k = 0; k <= 4; k++) rd(k, base + 24'(k));
    rd(-1, base - 24'd1);
    // a reader hogging the memory must cost samples
    run_i <= 1'b1;
    rd_req_i <= 1'b1;
    cyc(40);
    run_i <= 1'b0;
    rd_req_i <= 1'b0;
    cyc(24);
    cmp("dropped_o", 64'(dropped), 64'h1);
    end_sim;
  end
endmodule : testbench
`default_nettype wire
